// ===== logic/ctu_pkg.sv
package ctu_pkg;
  // apb byte offsets
  localparam logic [7:0] CTU_UNIT_CONTROL_OFF    = 8'h00;
  localparam logic [7:0] CTU_CURRENT_CONTROL_OFF = 8'h04;
  localparam logic [15:0] CTU_UNIT_CONTROL_RST    = 16'h0000;
  localparam logic [15:0] CTU_CURRENT_CONTROL_RST = 16'h0000;
  // writable masks; zero bits ignore writes and read as zero
  localparam logic [15:0] CTU_UNIT_CONTROL_MASK    = 16'hBFFF;
  localparam logic [15:0] CTU_CURRENT_CONTROL_MASK = 16'hFF00;
  // unit_control field positions
  localparam int CTU_UNIT_ENABLE_BIT  = 15;
  localparam int CTU_IDLE_STOP_BIT    = 13;
  localparam int CTU_DELAY_GEN_BIT    = 12;
  localparam int CTU_EDGE_PASS_BIT    = 11;
  localparam int CTU_EDGE_ORDER_BIT   = 10;
  localparam int CTU_DISCHARGE_BIT    = 9;
  localparam int CTU_TRIG_OUT_BIT     = 8;
  localparam int CTU_SECOND_POL_BIT   = 7;
  localparam int CTU_SECOND_SEL_LSB   = 5;
  localparam int CTU_FIRST_POL_BIT    = 4;
  localparam int CTU_FIRST_SEL_LSB    = 2;
  localparam int CTU_SECOND_FLAG_BIT  = 1;
  localparam int CTU_FIRST_FLAG_BIT   = 0;
  // current_source_control field positions
  localparam int CTU_TRIM_LSB         = 10;
  localparam int CTU_RANGE_LSB        = 8;
  // source select encoding
  localparam logic [1:0] CTU_SRC_PIN_A = 2'h3;
  localparam logic [1:0] CTU_SRC_PIN_B = 2'h2;
  localparam logic [1:0] CTU_SRC_OC    = 2'h1;
  localparam logic [1:0] CTU_SRC_TMR   = 2'h0;
  localparam logic [1:0] CTU_RANGE_OFF = 2'h0;
endpackage

// ===== logic/ctu_charge_timing_unit.sv
`timescale 1ns/1ps
module ctu_charge_timing_unit
  import ctu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ext_edge_pin_a,
  input  wire logic        ext_edge_pin_b,
  input  wire logic        output_compare_one,
  input  wire logic        first_timer,
  input  wire logic        idle_mode,
  input  wire logic        comparator_trip,
  output logic             measure_pulse,
  output logic             pulse_output,
  output logic             trigger_out,
  output logic             delay_route,
  output logic             delay_charge,
  output logic             source_grounded,
  output logic             source_on,
  output logic [1:0]       current_range,
  output logic [5:0]       current_trim
);

  // ***************************************************
  // register bus
  // ***************************************************
  logic [15:0] unit_control_r;
  logic [15:0] current_source_control_r;
  logic        wr_en;
  logic        rd_en;
  logic        hit_ctl;
  logic        hit_cur;
  logic        first_evt;
  logic        second_evt;
  logic        active;

  // a write lands at the edge where the master samples pready high
  assign wr_en   = psel && penable && pwrite && pready;
  assign rd_en   = psel && penable && !pwrite && !pready;
  assign hit_ctl = (paddr == CTU_UNIT_CONTROL_OFF);
  assign hit_cur = (paddr == CTU_CURRENT_CONTROL_OFF);

  function automatic logic [15:0] ctu_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st,
                                            input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (st[0]) v[7:0]  = wd[7:0];
    if (st[1]) v[15:8] = wd[15:8];
    return v & msk;
  endfunction

  // one wait state: answer in the cycle after the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit_ctl && !hit_cur;
      if (rd_en) begin
        if (hit_ctl) prdata <= {16'h0000, unit_control_r};
        else if (hit_cur) prdata <= {16'h0000, current_source_control_r};
        else prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      current_source_control_r <= CTU_CURRENT_CONTROL_RST;
    end else if (wr_en && hit_cur) begin
      current_source_control_r <= ctu_merge(current_source_control_r, pwdata,
                                            pstrb, CTU_CURRENT_CONTROL_MASK);
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_control_r <= CTU_UNIT_CONTROL_RST;
    end else begin
      if (wr_en && hit_ctl) begin
        unit_control_r <= ctu_merge(unit_control_r, pwdata, pstrb,
                                    CTU_UNIT_CONTROL_MASK);
        if (first_evt)
          unit_control_r[CTU_FIRST_FLAG_BIT] <= 1'b1;
        if (second_evt)
          unit_control_r[CTU_SECOND_FLAG_BIT] <= 1'b1;
      end else begin
        if (!active) begin
          // disabled unit holds its event state cleared
          unit_control_r[CTU_FIRST_FLAG_BIT]  <= 1'b0;
          unit_control_r[CTU_SECOND_FLAG_BIT] <= 1'b0;
        end else begin
          if (first_evt)
            unit_control_r[CTU_FIRST_FLAG_BIT] <= 1'b1;
          if (second_evt)
            unit_control_r[CTU_SECOND_FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  // ***************************************************
  // edge sources
  // ***************************************************
  logic [1:0] pin_a_sync_r;
  logic [1:0] pin_b_sync_r;
  logic [3:0] src_prev_r;
  logic [3:0] src_now;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a_sync_r <= 2'b00;
      pin_b_sync_r <= 2'b00;
    end else begin
      pin_a_sync_r <= {pin_a_sync_r[0], ext_edge_pin_a};
      pin_b_sync_r <= {pin_b_sync_r[0], ext_edge_pin_b};
    end
  end

  // index matches the source select encoding
  assign src_now = {pin_a_sync_r[1], pin_b_sync_r[1],
                    output_compare_one, first_timer};

  always_ff @(posedge clk) begin
    if (rst) src_prev_r <= 4'h0;
    else src_prev_r <= src_now;
  end

  function automatic logic ctu_edge(input logic [3:0] now,
                                    input logic [3:0] prev,
                                    input logic [1:0] sel,
                                    input logic       pol);
    logic n;
    logic p;
    n = now[sel];
    p = prev[sel];
    return pol ? (n && !p) : (!n && p);
  endfunction

  logic en_bit;
  logic pass;
  logic first_raw;
  logic second_raw;
  logic first_seen;

  assign en_bit = unit_control_r[CTU_UNIT_ENABLE_BIT];
  assign active = en_bit &&
                  !(unit_control_r[CTU_IDLE_STOP_BIT] && idle_mode);
  assign pass   = active && unit_control_r[CTU_EDGE_PASS_BIT];
  assign first_raw = ctu_edge(src_now, src_prev_r,
      unit_control_r[CTU_FIRST_SEL_LSB +: 2],
      unit_control_r[CTU_FIRST_POL_BIT]);
  assign second_raw = ctu_edge(src_now, src_prev_r,
      unit_control_r[CTU_SECOND_SEL_LSB +: 2],
      unit_control_r[CTU_SECOND_POL_BIT]);
  assign first_seen = unit_control_r[CTU_FIRST_FLAG_BIT];
  assign first_evt  = pass && first_raw;
  assign second_evt = pass && second_raw &&
      (!unit_control_r[CTU_EDGE_ORDER_BIT] || first_seen);

  // ***************************************************
  // pulse, delay and current source
  // ***************************************************
  logic delay_mode;
  logic trip_seen_r;
  assign delay_mode = unit_control_r[CTU_DELAY_GEN_BIT];

  // a simultaneous first and second event gives a zero-width pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      measure_pulse <= 1'b0;
    end else if (!active || delay_mode) begin
      measure_pulse <= 1'b0;
    end else if (second_evt) begin
      measure_pulse <= 1'b0;
    end else if (first_evt) begin
      measure_pulse <= 1'b1;
    end
  end

  // comparator trip is asynchronous to clk and a pulse is emitted once
  logic [1:0] trip_sync_r;
  always_ff @(posedge clk) begin
    if (rst) trip_sync_r <= 2'b00;
    else trip_sync_r <= {trip_sync_r[0], comparator_trip};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      delay_charge <= 1'b0;
      pulse_output <= 1'b0;
      trip_seen_r  <= 1'b0;
    end else if (!active || !delay_mode) begin
      delay_charge <= 1'b0;
      pulse_output <= 1'b0;
      trip_seen_r  <= 1'b0;
    end else begin
      pulse_output <= 1'b0;
      if (first_evt && !delay_charge) begin
        delay_charge <= 1'b1;
        trip_seen_r  <= 1'b0;
      end else if (delay_charge && trip_sync_r[1] && !trip_seen_r) begin
        pulse_output <= 1'b1;
        trip_seen_r  <= 1'b1;
        delay_charge <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_out     <= 1'b0;
      delay_route     <= 1'b0;
      source_grounded <= 1'b0;
      source_on       <= 1'b0;
      current_range   <= CTU_RANGE_OFF;
      current_trim    <= 6'h00;
    end else begin
      trigger_out     <= active && unit_control_r[CTU_TRIG_OUT_BIT] &&
                         (measure_pulse || pulse_output);
      delay_route     <= en_bit && delay_mode;
      source_grounded <= unit_control_r[CTU_DISCHARGE_BIT];
      current_range   <= current_source_control_r[CTU_RANGE_LSB +: 2];
      current_trim    <= current_source_control_r[CTU_TRIM_LSB +: 6];
      source_on       <= active &&
          (current_source_control_r[CTU_RANGE_LSB +: 2] != CTU_RANGE_OFF) &&
          (measure_pulse || delay_charge);
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  property p_flag_first;
    @(posedge clk) disable iff (rst)
      first_evt |=> unit_control_r[CTU_FIRST_FLAG_BIT];
  endproperty
  a_flag_first: assert property (p_flag_first)
    else $error("first flag not set after event");

  property p_flag_second;
    @(posedge clk) disable iff (rst)
      second_evt |=> unit_control_r[CTU_SECOND_FLAG_BIT];
  endproperty
  a_flag_second: assert property (p_flag_second)
    else $error("second flag not set after event");

  property p_block;
    @(posedge clk) disable iff (rst)
      !unit_control_r[CTU_EDGE_PASS_BIT] |-> !first_evt && !second_evt;
  endproperty
  a_block: assert property (p_block)
    else $error("edge passed while blocked");

  property p_order;
    @(posedge clk) disable iff (rst)
      (unit_control_r[CTU_EDGE_ORDER_BIT] && !first_seen) |-> !second_evt;
  endproperty
  a_order: assert property (p_order)
    else $error("second event before first in order mode");

  property p_pulse_start;
    @(posedge clk) disable iff (rst)
      (first_evt && !second_evt && !delay_mode) |=> measure_pulse;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("measure pulse did not start");

  property p_pulse_end;
    @(posedge clk) disable iff (rst)
      second_evt |=> !measure_pulse;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("measure pulse did not end");

  property p_disabled;
    @(posedge clk) disable iff (rst)
      !en_bit [*2] |-> !measure_pulse && !pulse_output && !source_on;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("activity while unit disabled");

  property p_trig;
    @(posedge clk) disable iff (rst)
      !$past(unit_control_r[CTU_TRIG_OUT_BIT]) |-> !trigger_out;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger out while disabled");

  property p_range;
    @(posedge clk) disable iff (rst)
      1'b1 |=> current_range ==
               $past(current_source_control_r[CTU_RANGE_LSB +: 2]);
  endproperty
  a_range: assert property (p_range)
    else $error("range output does not follow register");

  property p_idle;
    @(posedge clk) disable iff (rst)
      (unit_control_r[CTU_IDLE_STOP_BIT] && idle_mode) |->
        !first_evt && !second_evt;
  endproperty
  a_idle: assert property (p_idle)
    else $error("edge passed while stopped in idle");

  property p_pulse_once;
    @(posedge clk) disable iff (rst)
      pulse_output |=> !pulse_output;
  endproperty
  a_pulse_once: assert property (p_pulse_once)
    else $error("delay pulse longer than one cycle");

endmodule

// ===== tb/ctu_far_side.sv
`timescale 1ns/1ps
// ********************************
// edge sources and comparator two
// ********************************
module ctu_far_side
  import ctu_pkg::*;
#(
  parameter int TRIP_CYCLES = 6
)(
  input  wire logic clk,
  input  wire logic delay_charge,
  output logic      ext_edge_pin_a,
  output logic      ext_edge_pin_b,
  output logic      output_compare_one,
  output logic      first_timer,
  output logic      comparator_trip
);
  int charge_cnt;
  initial begin
    {ext_edge_pin_a, ext_edge_pin_b} = 2'h0;
    {output_compare_one, first_timer} = 2'h0;
    comparator_trip = 1'b0;
    charge_cnt = 0;
  end
  // delay capacitor ramps while charged and drops to zero the cycle after release
  always @(posedge clk) begin
    charge_cnt <= delay_charge ? charge_cnt + 1 : 0;
    comparator_trip <= delay_charge && (charge_cnt >= TRIP_CYCLES);
  end
  task automatic drive(input logic [1:0] sel, input logic v);
    @(posedge clk);
    case (sel)
      CTU_SRC_PIN_A: ext_edge_pin_a <= v;
      CTU_SRC_PIN_B: ext_edge_pin_b <= v;
      CTU_SRC_OC:    output_compare_one <= v;
      default:       first_timer <= v;
    endcase
  endtask
  task automatic set_all(input logic v);
    @(posedge clk);
    {ext_edge_pin_a, ext_edge_pin_b} <= {v, v};
    {output_compare_one, first_timer} <= {v, v};
  endtask
endmodule

// ===== tb/test_edge_timed_charge_control.sv
`timescale 1ns/1ps
module test_edge_timed_charge_control;
  import ctu_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, idle_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pin_a, pin_b, oc, tmr, trip, measure_pulse, pulse_output;
  logic        trigger_out, delay_route, delay_charge, source_grounded;
  logic        source_on;
  logic [1:0]  current_range;
  logic [5:0]  current_trim;
  int          err_count = 0;
  int          cmp_count = 0;
  localparam logic [7:0] UC = CTU_UNIT_CONTROL_OFF;
  localparam logic [7:0] CC = CTU_CURRENT_CONTROL_OFF;

  ctu_charge_timing_unit DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_edge_pin_a(pin_a), .ext_edge_pin_b(pin_b),
    .output_compare_one(oc), .first_timer(tmr), .idle_mode(idle_mode),
    .comparator_trip(trip), .measure_pulse(measure_pulse),
    .pulse_output(pulse_output), .trigger_out(trigger_out),
    .delay_route(delay_route), .delay_charge(delay_charge),
    .source_grounded(source_grounded), .source_on(source_on),
    .current_range(current_range), .current_trim(current_trim));
  ctu_far_side FAR (.clk(clk), .delay_charge(delay_charge),
    .ext_edge_pin_a(pin_a), .ext_edge_pin_b(pin_b),
    .output_compare_one(oc), .first_timer(tmr), .comparator_trip(trip));

  always #4 clk = ~clk;

  // ********************************
  // bus and compare helpers
  // ********************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x, "read data");
    chk(e, xe, "read error");
  endtask
  // enabled unit with edges passed, plus extra control bits
  function automatic logic [31:0] cfg(input logic [1:0] s1, input logic p1,
      input logic [1:0] s2, input logic p2, input logic [15:0] x);
    cfg = {16'h0000, x | 16'h8800 | {8'h00, p2, s2, p1, s1, 2'b00}};
  endfunction

  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs();
    rd_chk(UC, 32'h0000_0000, 1'b0);
    rd_chk(CC, 32'h0000_0000, 1'b0);
    rd_chk(8'h08, 32'h0000_0000, 1'b1);
    wr(UC, 32'hffff_ffff);
    rd_chk(UC, 32'h0000_bfff, 1'b0);
    wr(CC, 32'hffff_ffff);
    rd_chk(CC, 32'h0000_ff00, 1'b0);
    chk(current_range, 2'h3, "range");
    chk(current_trim, 6'h3f, "trim");
    wr(CC, 32'h0000_8500);
    wt(2);
    chk(current_range, 2'h1, "range");
    chk(current_trim, 6'h21, "trim");
    pstrb <= 4'h1;
    wr(CC, 32'h0000_0000);
    pstrb <= 4'hf;
    rd_chk(CC, 32'h0000_8500, 1'b0);
    wr(UC, 32'h0000_0000);
    rd_chk(UC, 32'h0000_0000, 1'b0);
  endtask
  task automatic t_measure();
    logic [1:0]  s1, s2;
    logic        p;
    logic [31:0] w;
    for (int i = 0; i < 8; i++) begin
      s1 = i[1:0];
      s2 = s1 + 2'd1;
      p = i[2];
      FAR.set_all(~p);
      wt(4);
      w = cfg(s1, p, s2, p, 16'h0000);
      wr(UC, w);
      FAR.drive(s1, p);
      wt(5);
      chk(measure_pulse, 1'b1, "pulse open");
      chk(trigger_out, 1'b0, "trigger off");
      chk(source_on, 1'b1, "source on");
      rd_chk(UC, w | 32'h1, 1'b0);
      FAR.drive(s2, p);
      wt(5);
      chk(measure_pulse, 1'b0, "pulse close");
      chk(source_on, 1'b0, "source off");
      rd_chk(UC, w | 32'h3, 1'b0);
    end
  endtask
  task automatic t_block();
    logic [31:0] w;
    FAR.set_all(1'b0);
    w = cfg(CTU_SRC_PIN_A, 1'b1, CTU_SRC_PIN_B, 1'b1, 16'h0000) ^ 32'h0800;
    wr(UC, w);
    FAR.drive(CTU_SRC_PIN_A, 1'b1);
    FAR.drive(CTU_SRC_PIN_B, 1'b1);
    wt(5);
    chk(measure_pulse, 1'b0, "blocked");
    rd_chk(UC, w, 1'b0);
    FAR.set_all(1'b0);
    w = cfg(CTU_SRC_PIN_A, 1'b1, CTU_SRC_PIN_B, 1'b1, 16'h0400);
    wr(UC, w);
    FAR.drive(CTU_SRC_PIN_B, 1'b1);
    wt(5);
    rd_chk(UC, w, 1'b0);
    FAR.drive(CTU_SRC_PIN_A, 1'b1);
    FAR.drive(CTU_SRC_PIN_B, 1'b0);
    wt(4);
    FAR.drive(CTU_SRC_PIN_B, 1'b1);
    wt(5);
    rd_chk(UC, w | 32'h3, 1'b0);
  endtask
  task automatic t_idle_off();
    logic [31:0] w;
    FAR.set_all(1'b0);
    idle_mode <= 1'b1;
    w = cfg(CTU_SRC_TMR, 1'b1, CTU_SRC_OC, 1'b1, 16'h2000);
    wr(UC, w);
    FAR.drive(CTU_SRC_TMR, 1'b1);
    wt(5);
    rd_chk(UC, w, 1'b0);
    FAR.set_all(1'b0);
    w = cfg(CTU_SRC_TMR, 1'b1, CTU_SRC_OC, 1'b1, 16'h0000);
    wr(UC, w);
    FAR.drive(CTU_SRC_TMR, 1'b1);
    wt(5);
    rd_chk(UC, w | 32'h1, 1'b0);
    idle_mode <= 1'b0;
    FAR.set_all(1'b0);
    w = w & 32'h7fff;
    wr(UC, w);
    FAR.drive(CTU_SRC_TMR, 1'b1);
    wt(5);
    chk(measure_pulse, 1'b0, "disabled");
    rd_chk(UC, w, 1'b0);
  endtask
  task automatic t_delay();
    int n = 0;
    FAR.set_all(1'b0);
    wr(UC, cfg(CTU_SRC_PIN_A, 1'b1, CTU_SRC_PIN_B, 1'b1, 16'h1300));
    wt(2);
    chk(delay_route, 1'b1, "route");
    chk(source_grounded, 1'b1, "ground");
    FAR.drive(CTU_SRC_PIN_A, 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (pulse_output !== 1'b1 && n < 40);
    chk(pulse_output, 1'b1, "delay pulse");
    @(posedge clk);
    chk(trigger_out, 1'b1, "trigger");
    chk(pulse_output, 1'b0, "pulse width");
  endtask

  // reset in mid-run returns registers and outputs to their idle values
  task automatic t_reset();
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    chk(delay_route, 1'b0, "reset route");
    chk(source_grounded, 1'b0, "reset ground");
    chk(current_range, 2'h0, "reset range");
    rd_chk(UC, 32'h0000_0000, 1'b0);
    rd_chk(CC, 32'h0000_0000, 1'b0);
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, idle_mode} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_measure();
    t_block();
    t_idle_off();
    t_delay();
    t_reset();
    final_report();
  end
endmodule
